// ---- core/pdiob_ctrl.sv ----
`timescale 1ns/1ps
module pdiob_ctrl
    import pdiob_pkg::*;
#(
    parameter logic [pdiob_pkg::DATA_W-1:0] DEV_ADDR = pdiob_pkg::DEV_ADDR_DEF,
    parameter int HAS_STATUS = 1
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [pdiob_pkg::DATA_W-1:0] dataBusIn, // data bus level
    output logic [pdiob_pkg::DATA_W-1:0] dataBusOut, // data bus drive value
    output logic dataBusOeB, // data bus drive, low = driving
    output logic [pdiob_pkg::FC_W-1:0] fcOut, // function code drive value
    output logic fcOeB, // function code drive, low = driving
    input wire logic requestStartWindow, // poll from processor
    output logic cycleRequest, // service request reply
    input wire logic statusIn, // status request line
    input wire logic addressIn, // address request line
    input wire logic dataIn, // data request line
    input wire logic dataOutWindow, // outgoing data marker
    input wire logic deviceAddressWindow, // device address marker
    input wire logic flagValidWindow, // carry valid marker
    input wire logic ioFlag, // returned carry
    input wire logic ioReset, // I/O reset from processor
    input wire logic priHiIn, // priority chain in, high level
    input wire logic priLoIn, // priority chain in, low level
    output logic priHiOut, // priority chain out, high level
    output logic priLoOut, // priority chain out, low level
    output logic stopRequest, // stop processor for status
    output logic upperMemRequest, // upper-memory select request
    output logic [pdiob_pkg::IRQ_W-1:0] interruptOut, // interrupt lines
    input wire logic [pdiob_pkg::IRQ_W-1:0] eventReq, // user events
    input wire logic [pdiob_pkg::DATA_W-1:0] statusWord, // status to report
    input wire logic cmdValid, // user command offered
    output logic cmdReady, // command accepted when both high
    input wire logic [pdiob_pkg::FC_W-1:0] cmdCode, // function code
    input wire logic [pdiob_pkg::DATA_W-1:0] cmdAddr, // address or PC value
    input wire logic [pdiob_pkg::DATA_W-1:0] cmdData, // word to send
    input wire logic cmdUrgent, // use high priority level
    output logic respValid, // one-cycle completion pulse
    output logic [pdiob_pkg::DATA_W-1:0] respData, // word returned
    output logic respCarry // carry returned
);
    import pdiob_pkg::*;

    // ----------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------
    // the sync lag must fit well inside the shortest strobe
    if (REQ_LINE_CYC <= 2 * SYNC_LAG_CYC || ALU_CYC <= SYNC_LAG_CYC) begin : g_bad_rate
        $error("clock too slow for bus strobes");
    end
    if (HAS_STATUS < 0 || HAS_STATUS > 1) begin : g_bad_status
        $error("HAS_STATUS must be 0 or 1");
    end

    // ----------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------
    logic [STROBE_W-1:0] strobeS;
    logic [STROBE_W-1:0] strobePrev_q;
    logic [DATA_W-1:0] dataS;
    logic rswS, stInS, adInS, dInS, dowS, dawS, iofwS, flagS, ioRstS, hiS, loS;
    logic rst;

    pdiob_sync #(.WIDTH(STROBE_W)) u_syncStrobe (
        .clk(clk),
        .rst_b(rst_b),
        .async({requestStartWindow, statusIn, addressIn, dataIn, dataOutWindow,
            deviceAddressWindow, flagValidWindow, ioFlag, ioReset, priHiIn, priLoIn}),
        .synced(strobeS)
    );
    pdiob_sync #(.WIDTH(DATA_W)) u_syncData (
        .clk(clk),
        .rst_b(rst_b),
        .async(dataBusIn),
        .synced(dataS)
    );

    assign {rswS, stInS, adInS, dInS, dowS, dawS, iofwS, flagS, ioRstS, hiS, loS} = strobeS;
    assign rst = !rst_b || ioRstS;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobePrev_q <= '0;
        end else begin
            strobePrev_q <= strobeS;
        end
    end

    logic stInRise, adInFall, dInFall, dowRise, dawRise, iofwRise;
    assign stInRise = stInS && !strobePrev_q[9];
    assign adInFall = !adInS && strobePrev_q[8];
    assign dInFall = !dInS && strobePrev_q[7];
    assign dowRise = dowS && !strobePrev_q[6];
    assign dawRise = dawS && !strobePrev_q[5];
    assign iofwRise = iofwS && !strobePrev_q[4];

    // ----------------------------------------------------------
    // device selection and start I/O
    // ----------------------------------------------------------
    pdiob_state_type state_q;
    logic sel_q;
    logic startPend_q;
    logic startEvent;
    logic accept;
    logic launchStart;

    // a table address arriving outside a transfer means start I/O
    assign startEvent = sel_q && dowRise && (state_q == ST_IDLE);
    assign accept = cmdValid && cmdReady;
    assign launchStart = startPend_q && (state_q == ST_IDLE) && !accept;

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q <= 1'b0;
        end else if (dawRise) begin
            sel_q <= (dataS == DEV_ADDR);
        end
    end

    logic [DATA_W-1:0] tableAddr_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            startPend_q <= 1'b0;
            tableAddr_q <= '0;
        end else if (startEvent) begin
            startPend_q <= 1'b1;
            tableAddr_q <= dataS;
        end else if (launchStart) begin
            startPend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------
    logic [FC_W-1:0] code_q;
    logic [DATA_W-1:0] addr_q, data_q;
    logic urgent_q;
    logic gotIn_q, gotOut_q, gotFlag_q;
    logic grant;
    logic xferDone;

    assign xferDone = (gotIn_q || !needIn(code_q)) && (gotOut_q || !needOut(code_q))
        && (gotFlag_q || !needFlag(code_q));

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            code_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            urgent_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        code_q <= cmdCode;
                        addr_q <= cmdAddr;
                        data_q <= cmdData;
                        urgent_q <= cmdUrgent;
                        state_q <= ST_REQ;
                    end else if (launchStart) begin
                        code_q <= FC_ADD_N;
                        addr_q <= tableAddr_q;
                        data_q <= TABLE_STEP;
                        urgent_q <= 1'b1;
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (adInS && cycleRequest) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (adInFall) begin
                        state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (xferDone) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdReady <= 1'b0;
        end else begin
            cmdReady <= (state_q == ST_IDLE) && !accept && !launchStart;
        end
    end

    pdiob_chain u_chain (
        .clk(clk),
        .rst(rst),
        .hiIn(hiS),
        .loIn(loS),
        .wantHi((state_q == ST_REQ) && urgent_q),
        .wantLo((state_q == ST_REQ) && !urgent_q),
        .hiOut_q(priHiOut),
        .loOut_q(priLoOut),
        .grant_q(grant)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            cycleRequest <= 1'b0;
        end else if (state_q != ST_REQ || adInS) begin
            cycleRequest <= 1'b0;
        end else if (rswS && grant) begin
            cycleRequest <= 1'b1;
        end
    end

    // ----------------------------------------------------------
    // bus drivers
    // ----------------------------------------------------------
    // drive only in strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            dataBusOut <= '0;
            dataBusOeB <= 1'b1;
            fcOut <= '0;
            fcOeB <= 1'b1;
        end else begin
            dataBusOeB <= 1'b1;
            fcOeB <= 1'b1;
            if (state_q == ST_ADDR && adInS) begin
                fcOut <= code_q;
                fcOeB <= 1'b0;
                dataBusOut <= addr_q;
                dataBusOeB <= 1'b0;
            end else if (state_q == ST_XFER && dInS && needIn(code_q)) begin
                dataBusOut <= data_q;
                dataBusOeB <= 1'b0;
            end else if (HAS_STATUS == 1 && sel_q && stInS) begin
                dataBusOut <= statusWord;
                dataBusOeB <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_q == ST_IDLE) begin
            upperMemRequest <= 1'b0;
        end else if (state_q == ST_ADDR && adInS) begin
            upperMemRequest <= addr_q[LSB_IDX] && (code_q != FC_IN_BYTE);
        end
    end

    // ----------------------------------------------------------
    // returned word and carry
    // ----------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || (state_q == ST_REQ)) begin
            gotIn_q <= 1'b0;
            gotOut_q <= 1'b0;
            gotFlag_q <= 1'b0;
        end else if (state_q == ST_XFER) begin
            gotIn_q <= gotIn_q || dInFall;
            gotOut_q <= gotOut_q || dowRise;
            gotFlag_q <= gotFlag_q || iofwRise;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            respData <= '0;
            respCarry <= 1'b0;
            respValid <= 1'b0;
        end else begin
            respValid <= (state_q == ST_XFER) && xferDone;
            if (state_q == ST_XFER && dowRise) begin
                respData <= dataS;
            end
            if (state_q == ST_XFER && iofwRise) begin
                respCarry <= flagS;
            end
        end
    end

    // ----------------------------------------------------------
    // stop request and interrupts
    // ----------------------------------------------------------
    // cannot answer status; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            stopRequest <= 1'b0;
        end else if (HAS_STATUS == 0 && sel_q && stInRise) begin
            stopRequest <= 1'b1;
        end else if (respValid) begin
            stopRequest <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            interruptOut <= '0;
        end else begin
            interruptOut <= eventReq;
        end
    end

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    a_bus_release: assert property (@(posedge clk) disable iff (rst)
        !dataBusOeB |-> $past(adInS) || $past(dInS) || $past(stInS))
        else $error("data bus driven without request line");
    a_fc_address: assert property (@(posedge clk) disable iff (rst)
        !fcOeB |-> !dataBusOeB && fcOut == $past(code_q) && $past(adInS))
        else $error("function code outside address phase");
    a_addr_value: assert property (@(posedge clk) disable iff (rst)
        !fcOeB |-> dataBusOut == $past(addr_q))
        else $error("wrong address during address-in");
    a_poll_reply: assert property (@(posedge clk) disable iff (rst)
        $rose(cycleRequest) |-> $past(rswS) && $past(grant))
        else $error("cycle request without poll");
    a_status_word: assert property (@(posedge clk) disable iff (rst)
        (HAS_STATUS == 1 && sel_q && stInS && state_q == ST_IDLE) |=>
            !dataBusOeB && dataBusOut == $past(statusWord))
        else $error("status not driven");
    a_stop_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(stopRequest) |-> $past(stInRise) && HAS_STATUS == 0)
        else $error("stop request without status-in");
    a_io_reset: assert property (@(posedge clk) disable iff (!rst_b)
        ioRstS |=> state_q == ST_IDLE && dataBusOeB && !cycleRequest)
        else $error("I/O reset did not clear controller");
    a_upper_mem: assert property (@(posedge clk) disable iff (rst)
        $rose(upperMemRequest) |-> addr_q[LSB_IDX] && $past(adInS))
        else $error("upper memory request without odd address");
    a_start_code: assert property (@(posedge clk) disable iff (rst)
        (launchStart) |=> state_q == ST_REQ && code_q == FC_ADD_N
            && addr_q == $past(tableAddr_q))
        else $error("start I/O did not issue code 7");
endmodule

// ---- core/pdiob_pkg.sv ----
package pdiob_pkg;
    localparam int DATA_W = 16;
    localparam int FC_W = 4;
    localparam int IRQ_W = 8;
    localparam int STROBE_W = 11;
    // bus bit 15 (the LSB) sits at vector index 0
    localparam int LSB_IDX = 0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALU_CYCLE_NS = 160;
    localparam int REQ_LINE_NS = 320;
    localparam int ALU_CYC = ALU_CYCLE_NS / CLK_PERIOD_NS;
    localparam int REQ_LINE_CYC = REQ_LINE_NS / CLK_PERIOD_NS;
    localparam int SYNC_LAG_CYC = 3;
    localparam logic [FC_W-1:0] FC_ADD_OUT = 4'h1;
    localparam logic [FC_W-1:0] FC_IN_WORD = 4'h2;
    localparam logic [FC_W-1:0] FC_IN_BYTE = 4'h3;
    localparam logic [FC_W-1:0] FC_INC1 = 4'h4;
    localparam logic [FC_W-1:0] FC_INC2 = 4'h5;
    localparam logic [FC_W-1:0] FC_OUT_WORD = 4'h6;
    localparam logic [FC_W-1:0] FC_ADD_N = 4'h7;
    localparam logic [FC_W-1:0] FC_SET_PC = 4'h8;
    localparam logic [FC_W-1:0] FC_SHOW_ACC = 4'hC;
    localparam logic [FC_W-1:0] FC_SHOW_X2 = 4'hF;
    localparam logic [DATA_W-1:0] TABLE_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] DEV_ADDR_DEF = 16'h0001;

    typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_XFER} pdiob_state_type;

    // controller sends a word while data-in is up
    function automatic logic needIn(input logic [FC_W-1:0] c);
        needIn = (c == FC_ADD_OUT) || (c == FC_IN_WORD) || (c == FC_IN_BYTE)
            || (c == FC_ADD_N) || (c == FC_SET_PC);
    endfunction

    // processor returns a word under the data-out window
    function automatic logic needOut(input logic [FC_W-1:0] c);
        needOut = (c == FC_ADD_OUT) || (c == FC_INC1) || (c == FC_INC2)
            || (c == FC_OUT_WORD) || (c == FC_ADD_N) || (c >= FC_SHOW_ACC);
    endfunction

    // processor returns a carry under the flag-valid window
    function automatic logic needFlag(input logic [FC_W-1:0] c);
        needFlag = (c == FC_ADD_OUT) || (c == FC_INC1) || (c == FC_INC2)
            || (c == FC_ADD_N);
    endfunction
endpackage

// ---- core/pdiob_sync.sv ----
`timescale 1ns/1ps
module pdiob_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [WIDTH-1:0] async, // pin levels
    output logic [WIDTH-1:0] synced // two-stage result
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            synced <= '0;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule

// ---- core/pdiob_chain.sv ----
`timescale 1ns/1ps
module pdiob_chain (
    input wire logic clk, // system clock
    input wire logic rst, // combined reset, active high
    input wire logic hiIn, // high level chain in
    input wire logic loIn, // low level chain in
    input wire logic wantHi, // request at high level
    input wire logic wantLo, // request at low level
    output logic hiOut_q, // high level chain out
    output logic loOut_q, // low level chain out
    output logic grant_q // chain reaches us at our level
);
    // ----------------------------------------------------------
    // two levels on one chain
    // ----------------------------------------------------------
    // pass or block
    always_ff @(posedge clk) begin
        if (rst) begin
            hiOut_q <= 1'b0;
            loOut_q <= 1'b0;
            grant_q <= 1'b0;
        end else begin
            hiOut_q <= hiIn && !wantHi;
            loOut_q <= loIn && !wantLo && !wantHi;
            grant_q <= (wantHi && hiIn) || (wantLo && loIn);
        end
    end

    a_chain_block: assert property (@(posedge clk) disable iff (rst)
        hiOut_q |-> $past(hiIn) && !$past(wantHi))
        else $error("high chain passed while requesting");
endmodule

// ---- test/pdiob_proc_model.sv ----
`timescale 1ns/1ps
module pdiob_proc_model
    import pdiob_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic [pdiob_pkg::DATA_W-1:0] dataBusOut, // controller drive value
    input wire logic dataBusOeB, // controller drive, low = driving
    input wire logic [pdiob_pkg::FC_W-1:0] fcOut, // function code value
    input wire logic fcOeB, // function code drive, low = driving
    input wire logic cycleRequest, // poll reply
    output logic [pdiob_pkg::DATA_W-1:0] dataBusIn, // resolved bus level
    output logic requestStartWindow, // poll
    output logic statusIn, // status request line
    output logic addressIn, // address request line
    output logic dataIn, // data request line
    output logic dataOutWindow, // outgoing data marker
    output logic deviceAddressWindow, // device address marker
    output logic flagValidWindow, // carry valid marker
    output logic ioFlag, // returned carry
    output logic ioReset // reset of all controllers
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] regFile [4];
    logic [DATA_W-1:0] drv = '0;
    logic drvOn = 1'b0;
    logic [DATA_W-1:0] lastBus = '0;
    logic [FC_W-1:0] lastFc = '0;
    logic [DATA_W-1:0] lastAddr = '0;

    // shared wire; a released bus toggles so stale words never match
    always @(posedge clk) lastBus <= dataBusIn;
    assign dataBusIn = !dataBusOeB ? dataBusOut : (drvOn ? drv : ~lastBus);

    initial begin
        {requestStartWindow, statusIn, addressIn, dataIn} = 4'h0;
        {dataOutWindow, deviceAddressWindow, flagValidWindow, ioFlag, ioReset} = 5'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic take(input int line, output logic [DATA_W-1:0] w);
        if (line == 0) statusIn <= 1'b1;
        else if (line == 1) addressIn <= 1'b1;
        else dataIn <= 1'b1;
        hold(REQ_LINE_CYC);
        w = dataBusIn;
        if (line == 1) lastFc = fcOeB ? 4'h0 : fcOut;
        {statusIn, addressIn, dataIn} <= 3'h0;
        hold(6);
    endtask

    // word or carry for one ALU cycle
    task automatic give(input logic [DATA_W-1:0] w, input logic fl, dw, fw);
        drv <= w;
        drvOn <= dw;
        dataOutWindow <= dw;
        flagValidWindow <= fw;
        ioFlag <= fl;
        hold(ALU_CYC);
        {drvOn, dataOutWindow, flagValidWindow, ioFlag} <= 4'h0;
        hold(6);
    endtask

    task automatic select(input logic [DATA_W-1:0] a);
        drv <= a;
        drvOn <= 1'b1;
        deviceAddressWindow <= 1'b1;
        hold(ALU_CYC);
        {drvOn, deviceAddressWindow} <= 2'h0;
        hold(6);
    endtask

    // one poll, requests served at once
    task automatic serve(output logic ok);
        logic [DATA_W-1:0] n;
        logic [DATA_W:0] s;
        logic [3:0] a;
        requestStartWindow <= 1'b1;
        hold(ALU_CYC);
        requestStartWindow <= 1'b0;
        ok = cycleRequest;
        if (!ok) return;
        take(1, lastAddr);
        a = lastAddr[3:0];
        case (lastFc)
            FC_ADD_OUT: begin
                take(2, n);
                s = mem[a] + n;
                give(s[15:0], s[16], 1'b1, 1'b1);
            end
            FC_IN_WORD: take(2, mem[a]);
            FC_IN_BYTE: begin
                take(2, n);
                mem[a][7:0] = n[7:0];
            end
            FC_INC1, FC_INC2: begin
                s = mem[a] + (lastFc == FC_INC1 ? 17'h00001 : 17'h00002);
                give(mem[a], s[16], 1'b1, 1'b1);
                mem[a] = s[15:0];
            end
            FC_OUT_WORD: give(mem[a], 1'b0, 1'b1, 1'b0);
            FC_ADD_N: begin
                give(mem[a], 1'b0, 1'b1, 1'b0);
                take(2, n);
                s = mem[a] + n;
                mem[a] = s[15:0];
                give(n, s[16], 1'b0, 1'b1);
            end
            FC_SET_PC: take(2, regFile[1]);
            default: give(regFile[lastFc[1:0]], 1'b0, 1'b1, 1'b0);
        endcase
    endtask

    task automatic read_status(output logic [DATA_W-1:0] w);
        select(DEV_ADDR_DEF);
        take(0, w);
    endtask

    task automatic start_io(input logic [DATA_W-1:0] t, output logic ok);
        select(DEV_ADDR_DEF);
        give(t, 1'b0, 1'b1, 1'b0);
        serve(ok);
    endtask

    task automatic reset_io();
        ioReset <= 1'b1;
        hold(ALU_CYC);
        ioReset <= 1'b0;
        hold(6);
    endtask
endmodule

// ---- test/tb_pdiob_ctrl.sv ----
`timescale 1ns/1ps
module tb_pdiob_ctrl;
    import pdiob_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [DATA_W-1:0] dataBusIn, dataBusOut, respData, lastData;
    logic [DATA_W-1:0] statusWord = '0, cmdAddr = '0, cmdData = '0;
    logic [FC_W-1:0] fcOut;
    logic [FC_W-1:0] cmdCode = '0;
    logic [IRQ_W-1:0] interruptOut;
    logic [IRQ_W-1:0] eventReq = '0;
    logic dataBusOeB, fcOeB, requestStartWindow, cycleRequest, statusIn, addressIn, dataIn;
    logic dataOutWindow, deviceAddressWindow, flagValidWindow, ioFlag, ioReset, lastCarry;
    logic priHiOut, priLoOut, stopRequest, upperMemRequest, cmdReady, respValid, respCarry;
    logic cmdValid = 1'b0;
    logic cmdUrgent = 1'b0;
    logic ok, lastUp, priIn = 1'b1;
    logic [DATA_W:0] r;
    int errors = 0;
    int compares = 0;
    int respCount = 0;

    pdiob_ctrl u_pdiob_ctrl (.clk(clk), .rst_b(rst_b), .dataBusIn(dataBusIn),
        .dataBusOut(dataBusOut), .dataBusOeB(dataBusOeB), .fcOut(fcOut), .fcOeB(fcOeB),
        .requestStartWindow(requestStartWindow), .cycleRequest(cycleRequest),
        .statusIn(statusIn), .addressIn(addressIn), .dataIn(dataIn),
        .dataOutWindow(dataOutWindow), .deviceAddressWindow(deviceAddressWindow),
        .flagValidWindow(flagValidWindow), .ioFlag(ioFlag), .ioReset(ioReset),
        .priHiIn(priIn), .priLoIn(priIn), .priHiOut(priHiOut), .priLoOut(priLoOut),
        .stopRequest(stopRequest), .upperMemRequest(upperMemRequest),
        .interruptOut(interruptOut), .eventReq(eventReq), .statusWord(statusWord),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdUrgent(cmdUrgent), .respValid(respValid),
        .respData(respData), .respCarry(respCarry));

    pdiob_proc_model u_pdiob_proc_model (.clk(clk), .dataBusOut(dataBusOut),
        .dataBusOeB(dataBusOeB), .fcOut(fcOut), .fcOeB(fcOeB), .cycleRequest(cycleRequest),
        .dataBusIn(dataBusIn), .requestStartWindow(requestStartWindow), .statusIn(statusIn),
        .addressIn(addressIn), .dataIn(dataIn), .dataOutWindow(dataOutWindow),
        .deviceAddressWindow(deviceAddressWindow), .flagValidWindow(flagValidWindow),
        .ioFlag(ioFlag), .ioReset(ioReset));

    initial forever #5 clk = ~clk;

    always @(posedge clk) begin
        if (respValid === 1'b1) begin
            respCount <= respCount + 1;
            lastData <= respData;
            lastCarry <= respCarry;
        end
        if (fcOeB === 1'b0) lastUp <= upperMemRequest;
    end

    task automatic chk(input logic [DATA_W:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic offer(input logic [FC_W-1:0] c, input logic [DATA_W-1:0] a, d);
        int k;
        k = 0;
        while (cmdReady !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        cmdCode <= c;
        cmdAddr <= a;
        cmdData <= d;
        cmdValid <= 1'b1;
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask

    task automatic run(input logic [FC_W-1:0] c, input logic [DATA_W-1:0] a, d);
        int n0;
        int k;
        n0 = respCount;
        offer(c, a, d);
        u_pdiob_proc_model.serve(ok);
        k = 0;
        while (respCount == n0 && k < 100) begin
            @(posedge clk);
            k++;
        end
        chk(ok, 1, "no cycle request");
        chk(u_pdiob_proc_model.lastFc, c, "function code");
        if (c < FC_SHOW_ACC) chk(u_pdiob_proc_model.lastAddr, a, "address");
        chk(respCount - n0, 1, "response count");
        chk(lastUp, a[0] && c != FC_IN_BYTE, "upper mem");
        r = {lastCarry, lastData};
    endtask

    task automatic t_misc();
        logic [DATA_W-1:0] w;
        eventReq <= 8'h5A;
        repeat (2) @(posedge clk);
        chk(interruptOut, 8'h5A, "interrupt copy");
        u_pdiob_proc_model.mem[9] = 16'hA5C3;
        run(FC_OUT_WORD, 16'h0009, 16'h0000);
        chk(r[15:0], 16'hA5C3, "output word");
        statusWord <= 16'h4321;
        u_pdiob_proc_model.read_status(w);
        chk(w, 16'h4321, "status word");
        $display("test misc done");
    endtask

    task automatic t_arith();
        u_pdiob_proc_model.mem[3] = 16'hFFFF;
        u_pdiob_proc_model.mem[7] = 16'hFFFF;
        u_pdiob_proc_model.mem[2] = 16'hFFFE;
        run(FC_ADD_OUT, 16'h0003, 16'h0002);
        chk(r, 17'h10001, "sum and carry");
        chk(u_pdiob_proc_model.mem[3], 16'hFFFF, "memory kept");
        run(FC_INC1, 16'h0007, 16'h0000);
        chk(r, 17'h1FFFF, "inc1 word and carry");
        run(FC_INC2, 16'h0007, 16'h0000);
        chk(r, 17'h00000, "inc2 word and carry");
        chk(u_pdiob_proc_model.mem[7], 16'h0002, "incremented memory");
        run(FC_ADD_N, 16'h0002, 16'h0003);
        chk(r, 17'h1FFFE, "add n word and carry");
        chk(u_pdiob_proc_model.mem[2], 16'h0001, "add n memory");
        $display("test arith done");
    endtask

    task automatic t_write_regs();
        logic [DATA_W-1:0] exp [4];
        exp = '{16'h0AC0, 16'h1357, 16'h0A11, 16'h0A22};
        u_pdiob_proc_model.mem[6] = 16'hFF00;
        u_pdiob_proc_model.regFile = '{16'h0AC0, 16'h0000, 16'h0A11, 16'h0A22};
        run(FC_IN_WORD, 16'h0005, 16'h1234);
        chk(u_pdiob_proc_model.mem[5], 16'h1234, "word write");
        run(FC_IN_BYTE, 16'h0006, 16'h00AB);
        chk(u_pdiob_proc_model.mem[6], 16'hFFAB, "byte write");
        run(FC_SET_PC, 16'h1357, 16'h1357);
        for (int i = 0; i < 4; i++) begin
            run(4'(12 + i), 16'h0000, 16'h0000);
            chk(r[15:0], exp[i], "register show");
        end
        $display("test write_regs done");
    endtask

    task automatic t_start_reset();
        u_pdiob_proc_model.mem[4] = 16'h0100;
        u_pdiob_proc_model.start_io(16'h0004, ok);
        chk(ok, 1, "start cycle request");
        chk(u_pdiob_proc_model.lastFc, FC_ADD_N, "start code");
        chk(u_pdiob_proc_model.lastAddr, 16'h0004, "table address");
        chk(u_pdiob_proc_model.mem[4], 16'h0100 + TABLE_STEP, "table step");
        repeat (20) @(posedge clk);
        priIn <= 1'b0;
        offer(FC_OUT_WORD, 16'h0009, 16'h0000);
        u_pdiob_proc_model.serve(ok);
        chk(ok, 0, "chain blocked");
        priIn <= 1'b1;
        u_pdiob_proc_model.reset_io();
        u_pdiob_proc_model.serve(ok);
        chk(ok, 0, "request after reset");
        chk({cmdReady, dataBusOeB, fcOeB}, 3'h7, "idle after reset");
        $display("test start_reset done");
    endtask

    task automatic print_verdict();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_misc();
        t_arith();
        t_write_regs();
        t_start_reset();
        print_verdict();
    end
endmodule
